/* File: vbis_regs.sv */
// interrupt, status and configuration-memory registers of the slicer
// assumes single-cycle host read and write strobes on the host port
//
// Notes on behaviour
// RQ1: enabled sources drive the interrupt pin
// RQ2: status bits set regardless of mask
// RQ3: mask bit layout, reserved 7/3, reset zero
// RQ4: pin active when status and mask overlap
// RQ5: config bit1 reads live interrupt state
// RQ6: polarity bit0: 0 low, 1 high
// RQ7: open drain pin, polarity chooses driven state
// RQ8: config bit2 gates pixel outputs, resets one
// RQ9: memory holds 32 slots of 16 bytes
// RQ10: 26 predefined slots, two custom slots
// RQ11: data port access advances address counter
// RQ12: low and high registers load 9-bit counter
// RQ13: host sets line modes before memory access
// RQ14: slicer status bit order, overflow to timecode
// RQ15: status flags cleared only by writing one
// RQ16: line not fitting sets overflow, drops line
// RQ17: fitting lines still written during overflow
// RQ18: threshold event when word count exceeds threshold
// RQ19: occupancy and threshold counted in words
// RQ20: interrupt status bits sticky until written one
// RQ21: set wins over simultaneous clear
`timescale 1ns/10ps
`default_nettype none
module vbis_regs
	import vbis_pkg::*;
(
	input  wire logic        i_ref_clk,          // 20 MHz clock
	input  wire logic        i_rst,              // sync reset, high
	input  wire logic [7:0]  i_host_addr,        // register offset
	input  wire logic        i_host_wr,          // write strobe
	input  wire logic        i_host_rd,          // read strobe
	input  wire logic [7:0]  i_host_wdata,       // write data
	output logic      [7:0]  o_host_rdata,       // read data
	output logic             o_host_rvalid,      // read data valid
	input  wire logic        i_lock_state,       // decoder locked level
	input  wire logic        i_cycle_done,       // host cycle done pulse
	input  wire logic        i_bus_error,        // illegal access pulse
	input  wire logic        i_line_hit,         // line number pulse
	input  wire logic        i_data_hit,         // data captured pulse
	input  wire logic [5:0]  i_avail_set,        // per-standard ready
	input  wire logic        i_fifo_empty,       // fifo empty level
	input  wire logic [7:0]  i_fifo_words,       // fifo words held
	input  wire logic        i_line_req,         // line ready to store
	input  wire logic [8:0]  i_line_bytes,       // line bytes + header
	output logic             o_line_write,       // store the line
	output logic             o_line_drop,        // line discarded
	input  wire logic [8:0]  i_slicer_ram_addr,  // slicer memory index
	output logic      [7:0]  o_slicer_ram_data,  // slicer memory byte
	output logic             o_int_out,          // interrupt pin out
	output logic             o_int_oe,           // interrupt pin enable
	output logic             o_pixel_oe_allow    // pixel pins may drive
);

	logic [7:0] mask_q, mask_d;
	logic       pol_q, pol_d;
	logic       pix_en_q, pix_en_d;
	logic [7:0] thr_q, thr_d;
	logic [8:0] ram_ptr_q, ram_ptr_d;
	logic [7:0] int_stat_q, int_stat_d;
	logic [7:0] slc_stat_q, slc_stat_d;
	logic       int_active_q, int_active_d;
	logic       int_oe_q, int_oe_d;
	logic       lock_prev_q, lock_prev_d;
	logic       lock_seen_q, lock_seen_d;
	logic [7:0] rdata_q, rdata_d;
	logic       rvalid_q, rvalid_d;
	logic       line_wr_q, line_wr_d;
	logic       line_drop_q, line_drop_d;
	logic [7:0] sl_data_q, sl_data_d;

	logic       wr_stat, wr_mask, wr_cfg, wr_data, wr_low, wr_high;
	logic       wr_slc, wr_thr, rd_data;
	logic [7:0] int_set, int_clr, slc_set, slc_clr;
	logic [7:0] ram_rd_host, ram_rd_slicer;
	logic [7:0] free_words;
	logic [8:0] line_words;
	logic       line_fits;

	// host port decode
	assign wr_stat = i_host_wr && (i_host_addr == ADDR_INT_STATUS);
	assign wr_mask = i_host_wr && (i_host_addr == ADDR_INT_MASK);
	assign wr_cfg  = i_host_wr && (i_host_addr == ADDR_PIN_CFG);
	assign wr_data = i_host_wr && (i_host_addr == ADDR_RAM_DATA);
	assign wr_low  = i_host_wr && (i_host_addr == ADDR_RAM_LOW);
	assign wr_high = i_host_wr && (i_host_addr == ADDR_RAM_HIGH);
	assign wr_slc  = i_host_wr && (i_host_addr == ADDR_SLC_STATUS);
	assign wr_thr  = i_host_wr && (i_host_addr == ADDR_FIFO_THR);
	assign rd_data = i_host_rd && (i_host_addr == ADDR_RAM_DATA);

	// configuration memory, 32 slots of 16 bytes; the first 26 slots hold
	// predefined standards and two more are left for custom ones
	vbis_cfg_ram u_cfg_ram ( // RQ9 RQ10
		.i_ref_clk (i_ref_clk),
		.i_we      (wr_data),
		.i_waddr   (ram_ptr_q),
		.i_wdata   (i_host_wdata),
		.i_raddr_a (ram_ptr_q),
		.o_rdata_a (ram_rd_host),
		.i_raddr_b (i_slicer_ram_addr),
		.o_rdata_b (ram_rd_slicer)
	);

	// line admission in two-byte words, header included in the byte count
	assign free_words = FIFO_CAP_WORDS - i_fifo_words; // RQ19
	assign line_words = 9'((10'(i_line_bytes) + 10'd1) >> 1); // RQ19
	assign line_fits  = line_words <= {1'b0, free_words}; // RQ16 RQ17

	// event sources for the two status registers
	always_comb
	begin
		int_set = 8'h00;
		int_set[BIT_LOCK_EDGE]  = lock_seen_q && (i_lock_state != lock_prev_q);
		int_set[BIT_CYCLE_DONE] = i_cycle_done;
		int_set[BIT_BUS_ERROR]  = i_bus_error;
		int_set[BIT_FIFO_THR]   = i_fifo_words > thr_q; // RQ18
		int_set[BIT_LINE_HIT]   = i_line_hit;
		int_set[BIT_DATA_HIT]   = i_data_hit;
		int_clr = wr_stat ? i_host_wdata : 8'h00;
		slc_set = {i_line_req && !line_fits, 1'b0, i_avail_set}; // RQ14 RQ16
		slc_clr = wr_slc ? i_host_wdata : 8'h00;
	end

	// next state of the status, mask and pin logic
	always_comb
	begin
		// sticky flags, set beats clear, mask not involved
		int_stat_d = (int_stat_q & ~int_clr) | int_set; // RQ2 RQ20 RQ21
		int_stat_d[BIT_LOCK_STATE] = 1'b0;
		int_stat_d[3] = 1'b0;
		slc_stat_d = (slc_stat_q & ~slc_clr) | slc_set; // RQ15 RQ21
		slc_stat_d[BIT_FIFO_EMPTY] = 1'b0;
		mask_d = wr_mask ? (i_host_wdata & MASK_USED) : mask_q; // RQ3
		pol_d = wr_cfg ? i_host_wdata[BIT_INT_POL] : pol_q; // RQ6
		pix_en_d = wr_cfg ? i_host_wdata[BIT_PIX_EN] : pix_en_q; // RQ8
		thr_d = wr_thr ? i_host_wdata : thr_q;
		// pin asserted while any flag meets its enable
		int_active_d = |(int_stat_q & mask_q); // RQ1 RQ4
		// low mode: drive low on assert; high mode: drive low when idle
		int_oe_d = int_active_d ^ pol_q; // RQ7
		lock_prev_d = i_lock_state;
		lock_seen_d = 1'b1;
	end

	// status, mask and pin registers
	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
		begin
			int_stat_q   <= STAT_RST;
			slc_stat_q   <= STAT_RST;
			mask_q       <= MASK_RST;
			pol_q        <= POL_RST;
			pix_en_q     <= PIX_EN_RST;
			thr_q        <= THR_RST;
			int_active_q <= 1'b0;
			int_oe_q     <= 1'b0;
			lock_prev_q  <= 1'b0;
			lock_seen_q  <= 1'b0;
		end
		else
		begin
			int_stat_q   <= int_stat_d;
			slc_stat_q   <= slc_stat_d;
			mask_q       <= mask_d;
			pol_q        <= pol_d;
			pix_en_q     <= pix_en_d;
			thr_q        <= thr_d;
			int_active_q <= int_active_d;
			int_oe_q     <= int_oe_d;
			lock_prev_q  <= lock_prev_d;
			lock_seen_q  <= lock_seen_d;
		end
	end

	// address counter: load from low/high bytes, step on each data access
	always_comb
	begin
		ram_ptr_d = ram_ptr_q;
		if (wr_low)
			ram_ptr_d[7:0] = i_host_wdata; // RQ12
		else if (wr_high)
			ram_ptr_d[8] = i_host_wdata[0]; // RQ12
		else if (wr_data || rd_data)
			ram_ptr_d = ram_ptr_q + 9'd1; // RQ11
	end

	// address counter register
	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
			ram_ptr_q <= RAM_PTR_RST;
		else
			ram_ptr_q <= ram_ptr_d;
	end

	// read mux, line decision and slicer memory port
	always_comb
	begin
		rdata_d = 8'h00;
		case (i_host_addr)
			ADDR_INT_STATUS:
			begin
				rdata_d = int_stat_q;
				rdata_d[BIT_LOCK_STATE] = i_lock_state;
			end
			ADDR_INT_MASK:   rdata_d = mask_q;
			ADDR_PIN_CFG:
				rdata_d = {5'h00, pix_en_q, int_active_q, pol_q}; // RQ5
			ADDR_RAM_DATA:   rdata_d = ram_rd_host;
			ADDR_RAM_LOW:    rdata_d = ram_ptr_q[7:0];
			ADDR_RAM_HIGH:   rdata_d = {7'h00, ram_ptr_q[8]};
			ADDR_SLC_STATUS:
			begin
				rdata_d = slc_stat_q;
				rdata_d[BIT_FIFO_EMPTY] = i_fifo_empty; // RQ15
			end
			ADDR_FIFO_WORDS: rdata_d = i_fifo_words;
			ADDR_FIFO_THR:   rdata_d = thr_q;
			default:         rdata_d = 8'h00;
		endcase
		rvalid_d    = i_host_rd;
		line_wr_d   = i_line_req && line_fits; // RQ17
		line_drop_d = i_line_req && !line_fits; // RQ16
		sl_data_d   = ram_rd_slicer;
	end

	// host answer and datapath strobes
	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
		begin
			rdata_q     <= 8'h00;
			rvalid_q    <= 1'b0;
			line_wr_q   <= 1'b0;
			line_drop_q <= 1'b0;
			sl_data_q   <= 8'h00;
		end
		else
		begin
			rdata_q     <= rdata_d;
			rvalid_q    <= rvalid_d;
			line_wr_q   <= line_wr_d;
			line_drop_q <= line_drop_d;
			sl_data_q   <= sl_data_d;
		end
	end

	// outputs straight from flops except o_int_out, which is tied low; pin level is always low when enabled
	assign o_host_rdata      = rdata_q;
	assign o_host_rvalid     = rvalid_q;
	assign o_line_write      = line_wr_q;
	assign o_line_drop       = line_drop_q;
	assign o_slicer_ram_data = sl_data_q;
	assign o_int_out         = 1'b0;
	assign o_int_oe          = int_oe_q;
	assign o_pixel_oe_allow  = pix_en_q;

	// checks on the register behaviour
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (i_rst);

	sequence s_data_access;
		i_host_addr == ADDR_RAM_DATA && (i_host_rd || i_host_wr);
	endsequence

	sequence s_line_clear_with_set;
		wr_stat && i_host_wdata[BIT_LINE_HIT] && i_line_hit;
	endsequence

	chk_mask_gates_pin: assert property ( // RQ1
		(|(int_stat_q & mask_q)) |=>
			int_active_q ##0 (o_int_oe != $past(pol_q)))
		else $error("enabled flag did not assert the pin");

	chk_masked_quiet: assert property ( // RQ4
		!(|(int_stat_q & mask_q)) |=> !int_active_q)
		else $error("pin active with no enabled flag");

	chk_status_unmasked: assert property ( // RQ2
		(i_data_hit && !mask_q[BIT_DATA_HIT]) |=> int_stat_q[BIT_DATA_HIT])
		else $error("masked source failed to set status");

	chk_mask_reserved: assert property ( // RQ3
		mask_q[7] == 1'b0 && mask_q[3] == 1'b0)
		else $error("reserved mask bit set");

	chk_ptr_advance: assert property ( // RQ11
		s_data_access |=> ram_ptr_q == 9'($past(ram_ptr_q) + 9'd1))
		else $error("address counter did not advance");

	chk_addr_load: assert property ( // RQ12
		wr_low |=> ram_ptr_q[7:0] == $past(i_host_wdata))
		else $error("low address byte not loaded");

	chk_flag_sticky: assert property ( // RQ20
		(int_stat_q[BIT_LINE_HIT] && !wr_stat)
			|=> int_stat_q[BIT_LINE_HIT])
		else $error("status flag cleared without write");

	chk_set_wins: assert property ( // RQ21
		s_line_clear_with_set |=> int_stat_q[BIT_LINE_HIT])
		else $error("event lost against clear");

	chk_overflow_drop: assert property ( // RQ16
		(i_line_req && !line_fits) |=>
			o_line_drop && !o_line_write && slc_stat_q[BIT_FIFO_OVF])
		else $error("oversized line not dropped");

	chk_threshold_set: assert property ( // RQ18
		(i_fifo_words > thr_q) |=> int_stat_q[BIT_FIFO_THR])
		else $error("threshold event missed");

	chk_cfg_live_bit: assert property ( // RQ5
		(i_host_rd && i_host_addr == ADDR_PIN_CFG) |=>
			o_host_rvalid && o_host_rdata[BIT_INT_LIVE] == $past(int_active_q))
		else $error("live interrupt bit wrong");

endmodule
`default_nettype wire

/* File: vbis_pkg.sv */
// constants shared by the vertical-blanking slicer register block
// assumes an 8-bit host port with 8-bit register offsets
package vbis_pkg;

	// register offsets on the host port
	localparam logic [7:0] ADDR_INT_STATUS = 8'hc0;
	localparam logic [7:0] ADDR_INT_MASK   = 8'hc1;
	localparam logic [7:0] ADDR_PIN_CFG    = 8'hc2;
	localparam logic [7:0] ADDR_RAM_DATA   = 8'hc3;
	localparam logic [7:0] ADDR_RAM_LOW    = 8'hc4;
	localparam logic [7:0] ADDR_RAM_HIGH   = 8'hc5;
	localparam logic [7:0] ADDR_SLC_STATUS = 8'hc6;
	localparam logic [7:0] ADDR_FIFO_WORDS = 8'hc7;
	localparam logic [7:0] ADDR_FIFO_THR   = 8'hc8;

	// interrupt status and mask bit positions
	localparam int BIT_LOCK_STATE = 7;
	localparam int BIT_LOCK_EDGE  = 6;
	localparam int BIT_CYCLE_DONE = 5;
	localparam int BIT_BUS_ERROR  = 4;
	localparam int BIT_FIFO_THR   = 2;
	localparam int BIT_LINE_HIT   = 1;
	localparam int BIT_DATA_HIT   = 0;
	// usable mask bits: 7 and 3 are reserved
	localparam logic [7:0] MASK_USED = 8'h77;

	// pin configuration bit positions
	localparam int BIT_PIX_EN   = 2;
	localparam int BIT_INT_LIVE = 1;
	localparam int BIT_INT_POL  = 0;

	// slicer status bit positions
	localparam int BIT_FIFO_OVF   = 7;
	localparam int BIT_FIFO_EMPTY = 6;

	// reset values
	localparam logic [7:0] MASK_RST     = 8'h00;
	localparam logic       POL_RST      = 1'b0;
	localparam logic       PIX_EN_RST   = 1'b1;
	localparam logic [7:0] THR_RST      = 8'h80;
	localparam logic [8:0] RAM_PTR_RST  = 9'h000;
	localparam logic [7:0] STAT_RST     = 8'h00;

	// configuration memory shape
	localparam int RAM_BYTES      = 512;
	localparam int RAM_AW         = 9;
	localparam int RAM_CFGS       = 32;
	localparam int RAM_CFG_BYTES  = 16;
	localparam int RAM_PREDEF     = 26;
	localparam int RAM_CUSTOM     = 2;

	// fifo capacity in words of two bytes
	localparam logic [7:0] FIFO_CAP_WORDS = 8'hff;

endpackage

/* File: vbis_cfg_ram.sv */
// flip-flop store for the slicer configuration memory
// assumes one write port and two asynchronous read ports
`timescale 1ns/10ps
`default_nettype none
module vbis_cfg_ram
	import vbis_pkg::*;
(
	input  wire logic              i_ref_clk, // block clock
	input  wire logic              i_we,      // byte write strobe
	input  wire logic [RAM_AW-1:0] i_waddr,   // write byte index
	input  wire logic [7:0]        i_wdata,   // write byte
	input  wire logic [RAM_AW-1:0] i_raddr_a, // host read index
	output logic      [7:0]        o_rdata_a, // host read byte
	input  wire logic [RAM_AW-1:0] i_raddr_b, // slicer read index
	output logic      [7:0]        o_rdata_b  // slicer read byte
);

	logic [7:0] mem_q [RAM_BYTES];

	// one byte of storage per entry, 32 slots of 16 bytes
	genvar gi;
	generate
		for (gi = 0; gi < RAM_BYTES; gi++)
		begin : g_byte
			always_ff @(posedge i_ref_clk)
			begin
				if (i_we && (i_waddr == RAM_AW'(gi)))
					mem_q[gi] <= i_wdata;
			end
		end
	endgenerate

	// read both ports by index
	assign o_rdata_a = mem_q[i_raddr_a];
	assign o_rdata_b = mem_q[i_raddr_b];

endmodule
`default_nettype wire

/* File: vbis_host_model.sv */
// host processor model driving the slicer block register port
// assumes the bench calls its tasks and shares the block clock
`timescale 1ns/10ps
`default_nettype none
module vbis_host
(
	input  wire logic       i_ref_clk, // block clock
	input  wire logic [7:0] i_rdata,   // read data
	input  wire logic       i_rvalid,  // read data valid
	output logic      [7:0] o_addr,    // register offset
	output logic            o_wr,      // write strobe
	output logic            o_rd,      // read strobe
	output logic      [7:0] o_wdata    // write data
);
	// idle port at time zero
	initial
	begin
		o_addr  = 8'h00;
		o_wr    = 1'b0;
		o_rd    = 1'b0;
		o_wdata = 8'h00;
	end
	// one-cycle write strobe, no acknowledge; data bus flips after
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_ref_clk);
		o_addr  <= a;
		o_wdata <= d;
		o_wr    <= 1'b1;
		@(posedge i_ref_clk);
		o_wr    <= 1'b0;
		o_wdata <= ~d;
	endtask
	// read strobe, data taken at the edge that shows valid
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		int n;
		@(posedge i_ref_clk);
		o_addr <= a;
		o_rd   <= 1'b1;
		@(posedge i_ref_clk);
		o_rd   <= 1'b0;
		n = 0;
		do
		begin
			@(posedge i_ref_clk);
			n++;
		end
		while (i_rvalid !== 1'b1 && n < 4);
		d = (i_rvalid === 1'b1) ? i_rdata : 'x;
	endtask
endmodule
`default_nettype wire

/* File: vbis_regs_tb.sv */
// self-checking bench for the slicer interrupt, status and memory registers
// assumes line modes are preset by the host before memory access
`timescale 1ns/10ps
`default_nettype none
`define chk(g, e) begin comparisons++; if ((g) !== (e)) begin \
	error_cnt++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module vbis_regs_tb
	import vbis_pkg::*;
;
	logic       clk, rst, wr, rd, rvalid, lock, fempty, lreq;
	logic       lwr, ldrop, int_out, int_oe, pix;
	logic [7:0] addr, wdata, rdata, fwords, srdata;
	logic [3:0] ev;
	logic [5:0] avail;
	logic [8:0] lbytes, sraddr;
	wire logic  int_pin;
	int         error_cnt, comparisons;
	int         srcs[4] = '{0, 1, 4, 5};
	// open-drain pin with pull-up
	assign int_pin = int_oe ? int_out : 1'b1;
	vbis_host i_host (.i_ref_clk(clk), .i_rdata(rdata), .i_rvalid(rvalid),
		.o_addr(addr), .o_wr(wr), .o_rd(rd), .o_wdata(wdata));
	vbis_regs i_dut (.i_ref_clk(clk), .i_rst(rst), .i_host_addr(addr),
		.i_host_wr(wr), .i_host_rd(rd), .i_host_wdata(wdata),
		.o_host_rdata(rdata), .o_host_rvalid(rvalid), .i_lock_state(lock),
		.i_cycle_done(ev[3]), .i_bus_error(ev[2]), .i_line_hit(ev[1]),
		.i_data_hit(ev[0]), .i_avail_set(avail), .i_fifo_empty(fempty),
		.i_fifo_words(fwords), .i_line_req(lreq), .i_line_bytes(lbytes),
		.o_line_write(lwr), .o_line_drop(ldrop), .i_slicer_ram_addr(sraddr),
		.o_slicer_ram_data(srdata), .o_int_out(int_out), .o_int_oe(int_oe),
		.o_pixel_oe_allow(pix));
	// 20 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task automatic test_done;
		if (error_cnt == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		i_host.rd(a, d);
		`chk(d, e)
	endtask
	task automatic pulse(input logic [3:0] v);
		@(posedge clk);
		ev <= v;
		@(posedge clk);
		ev <= 4'h0;
	endtask
	task automatic line(input logic [8:0] b, input logic [1:0] e);
		@(posedge clk);
		lreq   <= 1'b1;
		lbytes <= b;
		@(posedge clk);
		lreq   <= 1'b0;
		@(negedge clk);
		`chk({lwr, ldrop}, e)
	endtask
	// watchdog against a hung handshake
	initial
	begin
		tick(20000);
		error_cnt++;
		test_done();
	end
	// main sequence
	initial
	begin
		error_cnt = 0;
		comparisons = 0;
		rst = 1'b1;
		lock = 1'b0;
		ev = 4'h0;
		avail = 6'h00;
		fempty = 1'b1;
		fwords = 8'h00;
		lreq = 1'b0;
		lbytes = 9'h000;
		sraddr = 9'h000;
		tick(8);
		rst <= 1'b0;
		rchk(ADDR_INT_MASK, MASK_RST);
		rchk(ADDR_PIN_CFG, 8'h04);
		rchk(ADDR_FIFO_THR, THR_RST);
		`chk(int_pin, 1'b1)
		i_host.wr(ADDR_INT_MASK, 8'hff);
		rchk(ADDR_INT_MASK, 8'h77);
		i_host.wr(ADDR_INT_MASK, 8'h00);
		// masked sources still set their flags
		pulse(4'hf);
		tick(3);
		rchk(ADDR_INT_STATUS, 8'h33);
		`chk(int_pin, 1'b1)
		foreach (srcs[i])
		begin
			i_host.wr(ADDR_INT_MASK, 8'h01 << srcs[i]);
			tick(3);
			`chk(int_pin, 1'b0)
			rchk(ADDR_PIN_CFG, 8'h06);
			i_host.wr(ADDR_INT_STATUS, 8'h01 << srcs[i]);
			tick(3);
			`chk(int_pin, 1'b1)
		end
		rchk(ADDR_INT_STATUS, 8'h00);
		// event held across the clearing write
		@(posedge clk);
		ev <= 4'h1;
		i_host.wr(ADDR_INT_STATUS, 8'h01);
		ev <= 4'h0;
		rchk(ADDR_INT_STATUS, 8'h01);
		// active-high: driven low while idle, released when asserted
		i_host.wr(ADDR_PIN_CFG, 8'h05);
		tick(3);
		`chk(int_pin, 1'b0)
		i_host.wr(ADDR_INT_MASK, 8'h01);
		tick(3);
		`chk(int_pin, 1'b1)
		rchk(ADDR_PIN_CFG, 8'h07);
		i_host.wr(ADDR_INT_STATUS, 8'h01);
		i_host.wr(ADDR_PIN_CFG, 8'h00);
		tick(2);
		`chk(pix, 1'b0)
		i_host.wr(ADDR_PIN_CFG, 8'h04);
		tick(2);
		`chk(pix, 1'b1)
		// lock transition plus live level
		@(posedge clk);
		lock <= 1'b1;
		i_host.wr(ADDR_INT_MASK, 8'h40);
		tick(3);
		rchk(ADDR_INT_STATUS, 8'hc0);
		`chk(int_pin, 1'b0)
		i_host.wr(ADDR_INT_STATUS, 8'h40);
		i_host.wr(ADDR_INT_MASK, 8'h00);
		// line modes all ones, full field off, before memory access
		for (int a = 8'hd0; a <= 8'hfb; a++)
			i_host.wr(8'(a), 8'hff);
		i_host.wr(8'hcf, 8'h00);
		// memory: last byte, then a custom slot
		i_host.wr(ADDR_RAM_LOW, 8'hff);
		i_host.wr(ADDR_RAM_HIGH, 8'h01);
		i_host.wr(ADDR_RAM_DATA, 8'hcc);
		sraddr <= 9'h1ff;
		tick(2);
		`chk(srdata, 8'hcc)
		i_host.wr(ADDR_RAM_LOW, 8'ha0);
		i_host.wr(ADDR_RAM_HIGH, 8'h01);
		i_host.wr(ADDR_RAM_DATA, 8'haa);
		i_host.wr(ADDR_RAM_DATA, 8'hbb);
		rchk(ADDR_RAM_LOW, 8'ha2);
		rchk(ADDR_RAM_HIGH, 8'h01);
		i_host.wr(ADDR_RAM_LOW, 8'ha0);
		rchk(ADDR_RAM_DATA, 8'haa);
		rchk(ADDR_RAM_DATA, 8'hbb);
		// slicer ready flags
		@(posedge clk);
		avail <= 6'h3f;
		@(posedge clk);
		avail <= 6'h00;
		tick(2);
		rchk(ADDR_SLC_STATUS, 8'h7f);
		i_host.wr(ADDR_SLC_STATUS, 8'h20);
		rchk(ADDR_SLC_STATUS, 8'h5f);
		fempty <= 1'b0;
		rchk(ADDR_SLC_STATUS, 8'h1f);
		// admission with 15 words free
		fwords <= 8'hf0;
		line(9'h044, 2'b01);
		rchk(ADDR_SLC_STATUS, 8'h9f);
		line(9'h01d, 2'b10);
		line(9'h020, 2'b01);
		rchk(ADDR_FIFO_WORDS, 8'hf0);
		i_host.wr(ADDR_FIFO_WORDS, 8'h00);
		rchk(ADDR_FIFO_WORDS, 8'hf0);
		// threshold compares strictly above
		i_host.wr(ADDR_FIFO_THR, 8'hf0);
		i_host.wr(ADDR_INT_STATUS, 8'h04);
		rchk(ADDR_INT_STATUS, 8'h80);
		fwords <= 8'hf1;
		rchk(ADDR_INT_STATUS, 8'h84);
		rchk(8'hc9, 8'h00);
		test_done();
	end
endmodule
`default_nettype wire
